/* rtl/efs_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "efs_map.svh"
module efs_top #(
    parameter logic [31:0] CAP_DEFAULT = 32'h0000_0003
) (
    input  wire logic        clk,          // 200 MHz clock.
    input  wire logic        reset,        // Async reset, active high.
    input  wire logic [7:0]  wb_adr_i,     // Byte address.
    input  wire logic [31:0] wb_dat_i,     // Write data.
    output logic      [31:0] wb_dat_o,     // Read data.
    input  wire logic        wb_we_i,      // Write enable.
    input  wire logic [3:0]  wb_sel_i,     // Byte lanes.
    input  wire logic        wb_cyc_i,     // Cycle.
    input  wire logic        wb_stb_i,     // Strobe.
    output logic             wb_ack_o,     // Acknowledge.
    output logic             wb_err_o,     // Unmapped address.
    input  wire logic        shadow_stack_supported,    // Feature present.
    input  wire logic        branch_tracking_supported, // Feature present.
    output logic             mem_we,       // Memory write strobe.
    output logic      [63:0] mem_addr,     // Byte address of the word.
    output logic      [63:0] mem_data,     // Word written.
    output logic      [7:0]  mem_be        // Byte enables.
);
    efs_rec_if rif ();

    logic [31:0] ctrl_reg;       // Low word: gpr save region base.
    logic [31:0] cap_reg;
    logic [31:0] mask_reg;
    logic [1:0]  kind_reg;
    logic [31:0] err_reg;
    logic [63:0] faddr_reg;
    logic [31:0] cf_base_reg;
    logic [63:0] ssp_reg;
    logic [1:0]  trk_reg;
    logic [15:0] frames_reg;     // [15:8] frame count, [7:0] current.
    logic [31:0] desc_reg;
    logic [1:0]  desc_sel_reg;
    logic [63:0] desc_out_reg;
    logic [63:0] meta_reg;
    logic        meta_bad_reg;
    logic        go_reg;
    logic        cf_go_reg;
    logic [1:0]  step_reg;
    logic        recorded_reg;
    logic        skipped_reg;
    logic        busy_reg;
    efs_pkg::efs_state_t state_reg;
    logic [7:0]  misc_size;
    logic        wr, rd, hit;
    logic [31:0] rdat;

    assign rif.kind   = efs_pkg::efs_kind_t'(kind_reg);
    assign rif.addr   = faddr_reg;
    assign rif.err_in = err_reg;
    assign rif.us_in  = err_reg[`EFS_EC_US];

    efs_fmt u_fmt (
        .r    (rif.fmt),
        .cap  (cap_reg),
        .mask (mask_reg)
    );

    efs_size u_size (
        .cap       (cap_reg),
        .mask      (mask_reg),
        .misc_size (misc_size)
    );

    assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && !wb_err_o;
    assign rd = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o && !wb_err_o;

    // Address decode; anything unlisted is answered with an error.
    always_comb begin
        hit  = 1'b1;
        rdat = 32'h0;
        unique case (wb_adr_i)
            `EFS_A_CTRL:      rdat = ctrl_reg;
            `EFS_A_CAP:       rdat = cap_reg;
            `EFS_A_MASK:      rdat = mask_reg;
            `EFS_A_FAULT:     rdat = {30'h0, kind_reg};
            `EFS_A_ADDR_LO:   rdat = faddr_reg[31:0];
            `EFS_A_ADDR_HI:   rdat = faddr_reg[63:32];
            `EFS_A_FAULT_ERROR_CODE:     rdat = err_reg;
            `EFS_A_STATUS:    rdat = {28'h0, meta_bad_reg, skipped_reg,
                                      recorded_reg, busy_reg};
            `EFS_A_REC_ADDR:  rdat = ctrl_reg - 32'(`EFS_REC_SIZE);
            `EFS_A_MISC_SIZE: rdat = {24'h0, misc_size};
            `EFS_A_CF_ADDR:   rdat = cf_base_reg;
            `EFS_A_CF_SSP_LO: rdat = ssp_reg[31:0];
            `EFS_A_CF_SSP_HI: rdat = ssp_reg[63:32];
            `EFS_A_CF_TRK:    rdat = {30'h0, trk_reg};
            `EFS_A_FRAMES:    rdat = {16'h0, frames_reg};
            `EFS_A_DESC:      rdat = desc_reg;
            `EFS_A_DESC_OUT:  rdat = desc_out_reg[31:0];
            `EFS_A_META:      rdat = meta_reg[31:0];
            default:          hit  = 1'b0;
        endcase
    end

    // Single-cycle answer; ack drops the cycle after it was given.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            wb_ack_o <= (wr || rd) && hit;
            wb_err_o <= (wr || rd) && !hit;
            wb_dat_o <= rd ? rdat : 32'h0;
        end
    end

    // Software writes; a fault write launches the record save.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ctrl_reg    <= 32'h0;
            cap_reg     <= CAP_DEFAULT;
            mask_reg    <= 32'h0;
            kind_reg    <= 2'h0;
            err_reg     <= 32'h0;
            faddr_reg   <= 64'h0;
            cf_base_reg <= 32'h0;
            ssp_reg     <= 64'h0;
            trk_reg     <= 2'h0;
            frames_reg  <= 16'h0;
            desc_reg    <= 32'h0;
            meta_reg    <= 64'h0;
            go_reg      <= 1'b0;
            cf_go_reg   <= 1'b0;
        end else begin
            go_reg    <= wr && wb_adr_i == `EFS_A_FAULT && !busy_reg;
            cf_go_reg <= wr && wb_adr_i == `EFS_A_CF_TRK && !busy_reg;
            if (wr && wb_sel_i == 4'hF) begin
                unique case (wb_adr_i)
                    `EFS_A_CTRL:      ctrl_reg <= wb_dat_i;
                    `EFS_A_CAP:       cap_reg <= wb_dat_i;
                    `EFS_A_MASK:      mask_reg <= wb_dat_i;
                    `EFS_A_FAULT:     kind_reg <= wb_dat_i[1:0];
                    `EFS_A_ADDR_LO:   faddr_reg[31:0] <= wb_dat_i;
                    `EFS_A_ADDR_HI:   faddr_reg[63:32] <= wb_dat_i;
                    `EFS_A_FAULT_ERROR_CODE:     err_reg <= wb_dat_i;
                    `EFS_A_CF_ADDR:   cf_base_reg <= wb_dat_i;
                    `EFS_A_CF_SSP_LO: ssp_reg[31:0] <= wb_dat_i;
                    `EFS_A_CF_SSP_HI: ssp_reg[63:32] <= wb_dat_i;
                    `EFS_A_CF_TRK:    trk_reg <= wb_dat_i[1:0];
                    `EFS_A_FRAMES:    frames_reg <= wb_dat_i[15:0];
                    `EFS_A_DESC:      desc_reg <= wb_dat_i;
                    `EFS_A_META:      meta_reg[31:0] <= wb_dat_i;
                    default:          ;
                endcase
            end
        end
    end

    // Descriptor field pick: low bits select one of four 8-byte words.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            desc_sel_reg <= 2'h0;
            desc_out_reg <= 64'h0;
            meta_bad_reg <= 1'b0;
        end else begin
            desc_sel_reg <= desc_reg[3:2];
            // Field address = base + 8*index over 0,8,16,24.
            desc_out_reg <= {32'h0, (desc_reg & ~32'(`EFS_DESC_ALIGN - 1))
                            + {27'h0, desc_sel_reg, 3'h0}};
            // Upper flag bits must be zero; the 56 bytes are not stored.
            meta_bad_reg <= meta_reg[63:16] != 48'h0
                            || meta_reg[7:6] != 2'h0;
        end
    end

    // Save sequencer: two 8-byte writes per record or tracker frame.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_reg    <= efs_pkg::EFS_IDLE;
            step_reg     <= 2'h0;
            busy_reg     <= 1'b0;
            recorded_reg <= 1'b0;
            skipped_reg  <= 1'b0;
            mem_we       <= 1'b0;
            mem_addr     <= 64'h0;
            mem_data     <= 64'h0;
            mem_be       <= 8'h00;
        end else begin
            mem_we <= 1'b0;
            unique case (state_reg)
                efs_pkg::EFS_IDLE: begin
                    if (go_reg) begin
                        // Component 0 is written only when selected.
                        if (rif.take && misc_size != 8'h00) begin
                            busy_reg     <= 1'b1;
                            step_reg     <= 2'h0;
                            state_reg    <= efs_pkg::EFS_WR;
                            recorded_reg <= 1'b1;
                            skipped_reg  <= 1'b0;
                        end else begin
                            skipped_reg  <= 1'b1;
                            recorded_reg <= 1'b0;
                        end
                    end else if (cf_go_reg) begin
                        busy_reg  <= 1'b1;
                        step_reg  <= 2'h2;
                        state_reg <= efs_pkg::EFS_WR;
                    end
                end
                efs_pkg::EFS_WR: begin
                    mem_we <= 1'b1;
                    mem_be <= 8'hFF;
                    unique case (step_reg)
                        2'h0: begin
                            mem_addr <= {32'h0, ctrl_reg - 32'(`EFS_REC_SIZE)}
                                        + 64'(`EFS_REC_OFS_ADDR);
                            mem_data <= rif.rec_addr;
                        end
                        2'h1: begin
                            mem_addr <= {32'h0, ctrl_reg - 32'(`EFS_REC_SIZE)}
                                        + 64'(`EFS_REC_OFS_ERR);
                            // Upper half is the reserved word.
                            mem_data <= {32'h0, rif.rec_err};
                        end
                        2'h2: begin
                            // Base + current frame * frame size.
                            mem_addr <= {32'h0, cf_base_reg}
                                + 64'({frames_reg[7:0], 4'h0})
                                + 64'(`EFS_CF_OFS_SSP);
                            mem_data <= shadow_stack_supported ? ssp_reg
                                        : 64'h0;
                        end
                        default: begin
                            mem_addr <= {32'h0, cf_base_reg}
                                + 64'({frames_reg[7:0], 4'h0})
                                + 64'(`EFS_CF_OFS_TRK);
                            mem_data <= branch_tracking_supported
                                ? {62'h0, trk_reg} : 64'h0;
                        end
                    endcase
                    step_reg <= step_reg + 2'h1;
                    if (step_reg == 2'h1 || step_reg == 2'h3) begin
                        state_reg <= efs_pkg::EFS_DONE;
                    end
                end
                efs_pkg::EFS_DONE: begin
                    busy_reg  <= 1'b0;
                    state_reg <= efs_pkg::EFS_IDLE;
                end
                default: state_reg <= efs_pkg::EFS_IDLE;
            endcase
        end
    end

    // Frame index must stay inside the frame count.
    property p_frame_range;
        @(posedge clk) disable iff (reset)
        (mem_we && step_reg == 2'h3) |-> frames_reg[7:0] < frames_reg[15:8];
    endproperty
    a_frame_range: assert property (p_frame_range)
        else $error("Current frame beyond frame count.");

    sequence s_launch;
        go_reg && rif.take && misc_size != 8'h00 &&
            state_reg == efs_pkg::EFS_IDLE;
    endsequence
    property p_record;
        @(posedge clk) disable iff (reset)
        s_launch |=> ##1 (mem_we
            && mem_addr == {32'h0, ctrl_reg - 32'(`EFS_REC_SIZE)});
    endproperty
    a_record: assert property (p_record)
        else $error("Record not written below the save region.");

    property p_us;
        @(posedge clk) disable iff (reset)
        rif.kind == efs_pkg::EFS_PF && rif.take |-> rif.rec_err[2];
    endproperty
    a_us: assert property (p_us)
        else $error("User bit not set in recorded error code.");

    property p_skip;
        @(posedge clk) disable iff (reset)
        (go_reg && !mask_reg[0] && kind_reg != 2'h3) |=> ##1 !mem_we;
    endproperty
    a_skip: assert property (p_skip)
        else $error("Unselected component was written.");

    property p_size;
        @(posedge clk) disable iff (reset)
        cap_reg == 32'h0 |-> misc_size == 8'h00;
    endproperty
    a_size: assert property (p_size)
        else $error("Misc region present with zero capability.");

    property p_addr_clr;
        @(posedge clk) disable iff (reset)
        kind_reg == 2'h2 |-> rif.rec_addr == 64'h0;
    endproperty
    a_addr_clr: assert property (p_addr_clr)
        else $error("Address not cleared for protection fault.");

    // Protection codes keep their selector bits, so only page faults are
    // held to the reserved gap between bits 6 and 14.
    property p_rsv;
        @(posedge clk) disable iff (reset)
        rif.rec_err[31:16] == 16'h0
        && (rif.kind != efs_pkg::EFS_PF || rif.rec_err[14:6] == 9'h0);
    endproperty
    a_rsv: assert property (p_rsv)
        else $error("Reserved error bits not zero.");

    property p_sup;
        @(posedge clk) disable iff (reset)
        (kind_reg == 2'h1 && !err_reg[2]) |-> !rif.take;
    endproperty
    a_sup: assert property (p_sup)
        else $error("Supervisor page fault would be recorded.");
endmodule : efs_top
`default_nettype wire

/* common/efs_map.svh */
`ifndef EFS_MAP_SVH
`define EFS_MAP_SVH
// Wishbone register byte addresses.
`define EFS_A_CTRL      8'h00
`define EFS_A_CAP       8'h04
`define EFS_A_MASK      8'h08
`define EFS_A_FAULT     8'h0C
`define EFS_A_ADDR_LO   8'h10
`define EFS_A_ADDR_HI   8'h14
`define EFS_A_FAULT_ERROR_CODE     8'h18
`define EFS_A_STATUS    8'h1C
`define EFS_A_REC_ADDR  8'h20
`define EFS_A_MISC_SIZE 8'h24
`define EFS_A_CF_ADDR   8'h28
`define EFS_A_CF_SSP_LO 8'h2C
`define EFS_A_CF_SSP_HI 8'h30
`define EFS_A_CF_TRK    8'h34
`define EFS_A_FRAMES    8'h38
`define EFS_A_DESC      8'h3C
`define EFS_A_DESC_OUT  8'h40
`define EFS_A_META      8'h44
// Record layout and sizes in bytes.
`define EFS_REC_SIZE    16
`define EFS_REC_OFS_ADDR 0
`define EFS_REC_OFS_ERR 8
`define EFS_REC_OFS_RSV 12
`define EFS_CF_FRAME    16
`define EFS_CF_OFS_SSP  0
`define EFS_CF_OFS_TRK  8
`define EFS_DESC_ALIGN  32
`define EFS_META_RSV    56
// Error code bit positions.
`define EFS_EC_P        0
`define EFS_EC_WR       1
`define EFS_EC_US       2
`define EFS_EC_RSVD     3
`define EFS_EC_ID       4
`define EFS_EC_PK       5
`define EFS_EC_MAP      15
// Fault kind codes on the fault register.
`define EFS_K_PF        2'h1
`define EFS_K_GP        2'h2
`define EFS_K_CP        2'h3
`endif

/* common/efs_pkg.sv */
`default_nettype none
package efs_pkg;
    typedef enum logic [1:0] {
        EFS_NONE = 2'b00,
        EFS_PF   = 2'b01,
        EFS_GP   = 2'b10,
        EFS_CP   = 2'b11
    } efs_kind_t;
    typedef enum logic [1:0] {
        EFS_IDLE  = 2'b00,
        EFS_WR    = 2'b01,
        EFS_DONE  = 2'b10
    } efs_state_t;
endpackage : efs_pkg
`default_nettype wire

/* common/efs_rec_if.sv */
`timescale 1ns/1ps
`default_nettype none
// Carries a fault into the record formatter and the formatted record out.
interface efs_rec_if;
    efs_pkg::efs_kind_t kind;
    logic [63:0]        addr;
    logic [31:0]        err_in;
    logic               us_in;
    logic               take;
    logic [63:0]        rec_addr;
    logic [31:0]        rec_err;
    modport src (output kind, addr, err_in, us_in, input take, rec_addr,
                 rec_err);
    modport fmt (input kind, addr, err_in, us_in, output take, rec_addr,
                 rec_err);
endinterface : efs_rec_if
`default_nettype wire

/* rtl/efs_fmt.sv */
`timescale 1ns/1ps
`default_nettype none
`include "efs_map.svh"
module efs_fmt (
    efs_rec_if.fmt      r,       // Fault in, formatted fields out.
    input wire logic [31:0] cap, // Supported component word.
    input wire logic [31:0] mask // Enclave selection mask.
);
    // Decide whether a fault is recorded at all.
    always_comb begin
        unique case (r.kind)
            efs_pkg::EFS_PF: r.take = cap[0] && mask[0]
                                      && r.us_in;
            efs_pkg::EFS_GP: r.take = cap[0] && mask[0];
            efs_pkg::EFS_CP: r.take = cap[1] && mask[1];
            default:         r.take = 1'b0;
        endcase
    end
    // Page faults keep their address; the others clear it.
    assign r.rec_addr = (r.kind == efs_pkg::EFS_PF) ? r.addr : 64'h0;
    // Keep only defined bits so reserved ones read as zero.
    always_comb begin
        r.rec_err = 32'h0;
        if (r.kind == efs_pkg::EFS_PF) begin
            r.rec_err[`EFS_EC_P]    = r.err_in[`EFS_EC_P];
            r.rec_err[`EFS_EC_WR]   = r.err_in[`EFS_EC_WR];
            r.rec_err[`EFS_EC_RSVD] = r.err_in[`EFS_EC_RSVD];
            r.rec_err[`EFS_EC_ID]   = r.err_in[`EFS_EC_ID];
            r.rec_err[`EFS_EC_US]   = 1'b1;
            r.rec_err[`EFS_EC_PK]   = r.err_in[`EFS_EC_PK];
            r.rec_err[`EFS_EC_MAP]  = r.err_in[`EFS_EC_MAP];
        end else if (r.kind == efs_pkg::EFS_GP) begin
            r.rec_err[15:0] = r.err_in[15:0];
        end
    end
endmodule : efs_fmt
`default_nettype wire

/* rtl/efs_size.sv */
`timescale 1ns/1ps
`default_nettype none
`include "efs_map.svh"
module efs_size (
    input  wire logic [31:0] cap,       // Supported component word.
    input  wire logic [31:0] mask,      // Enclave selection mask.
    output logic      [7:0]  misc_size  // Bytes of the misc region.
);
    // Highest selected component sets the size; only the record is defined.
    // Bits 0 and 1 both select the fault record, so either one sizes it;
    // otherwise a control-protection fault could never be saved.
    always_comb begin
        misc_size = 8'h00;
        if (cap != 32'h0 && (mask[0] || mask[1])) begin
            misc_size = 8'(`EFS_REC_SIZE);
        end
    end
endmodule : efs_size
`default_nettype wire

/* verification/efs_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Frame memory as enclave software later reads it; keeps every store in order.
module efs_mem_model (
    input wire logic        clk,      // Clock.
    input wire logic        mem_we,   // Store strobe.
    input wire logic [63:0] mem_addr, // Byte address of the word.
    input wire logic [63:0] mem_data, // Word stored.
    input wire logic [7:0]  mem_be    // Byte enables.
);
    logic [63:0] wr_addr[$];
    logic [63:0] wr_data[$];
    // Only enabled bytes land, so a partial store cannot pass for a whole one.
    always @(posedge clk) begin
        logic [63:0] v;
        v = 64'h0;
        if (mem_we === 1'b1) begin
            for (int b = 0; b < 8; b++) begin
                if (mem_be[b] === 1'b1) begin
                    v[b*8 +: 8] = mem_data[b*8 +: 8];
                end
            end
            wr_addr.push_back(mem_addr);
            wr_data.push_back(v);
        end
    end
endmodule : efs_mem_model
`default_nettype wire

/* verification/efs_top_test.sv */
`timescale 1ns/1ps
`default_nettype none
`include "efs_map.svh"
module efs_top_test;
    logic        clk;
    logic        reset;
    logic [7:0]  wb_adr;
    logic [31:0] wb_dat;
    logic [31:0] wb_dat_o;
    logic        wb_we;
    logic [3:0]  wb_sel;
    logic        wb_cyc;
    logic        wb_stb;
    logic        wb_ack;
    logic        wb_err;
    logic        mem_we;
    logic [63:0] mem_addr;
    logic [63:0] mem_data;
    logic [7:0]  mem_be;
    logic        feat_sup;
    int          mismatches = 0;
    localparam logic [63:0] PF_VA = 64'h1234_5678_9ABC_DEF0; // Fault address.
    int          n_compared = 0;

    efs_top dut_u (.clk(clk), .reset(reset), .wb_adr_i(wb_adr),
        .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o), .wb_we_i(wb_we),
        .wb_sel_i(wb_sel), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_ack_o(wb_ack), .wb_err_o(wb_err),
        .shadow_stack_supported(feat_sup),
        .branch_tracking_supported(feat_sup), .mem_we(mem_we),
        .mem_addr(mem_addr), .mem_data(mem_data), .mem_be(mem_be));
    efs_mem_model mdl_u (.clk(clk), .mem_we(mem_we), .mem_addr(mem_addr),
        .mem_data(mem_data), .mem_be(mem_be));

    // Free-running 200 MHz clock.
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic wrap_up;
        if (mismatches == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : wrap_up

    task automatic chk(input string nm, input logic [63:0] ex,
                       input logic [63:0] got);
        n_compared++;
        if (got !== ex) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", nm, ex, got);
        end
    endtask : chk

    // One classic cycle; ack is sampled on the rising edge, and the request
    // is released only right after that edge.
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic e);
        int n;
        n = 0;
        @(posedge clk);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we  <= w;
        wb_adr <= a;
        wb_dat <= d;
        wb_sel <= 4'hF;
        do begin
            @(posedge clk);
            n++;
        end while (wb_ack !== 1'b1 && wb_err !== 1'b1 && n < 20);
        q = wb_dat_o;
        e = (wb_err === 1'b1);
        chk("bus_answer", 1'b1, n < 20);
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
    endtask : wb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        wb(1'b1, a, d, q, e);
        chk("write_err", 1'b0, e);
    endtask : wr

    task automatic rd(input string nm, input logic [7:0] a,
                      input logic [31:0] ex);
        logic [31:0] q;
        logic        e;
        wb(1'b0, a, 32'h0, q, e);
        chk(nm, ex, q);
    endtask : rd

    // Polls busy with a bound; the walk gives five cycles, this gives more.
    task automatic wait_idle;
        logic [31:0] q;
        logic        e;
        for (int i = 0; i < 8; i++) begin
            wb(1'b0, `EFS_A_STATUS, 32'h0, q, e);
            if (q[0] === 1'b0) break;
        end
        chk("busy", 1'b0, q[0]);
    endtask : wait_idle

    // Launches one fault and checks the two record stores below the base.
    task automatic fault(input logic [1:0] k, input logic [63:0] a,
                         input logic [31:0] ec, input logic rec,
                         input logic [63:0] xa, input logic chk_ec,
                         input logic [31:0] xec);
        int s;
        s = mdl_u.wr_addr.size();
        wr(`EFS_A_ADDR_LO, a[31:0]);
        wr(`EFS_A_ADDR_HI, a[63:32]);
        wr(`EFS_A_FAULT_ERROR_CODE, ec);
        wr(`EFS_A_FAULT, {30'h0, k});
        wait_idle();
        chk("stores", rec ? s + 2 : s, mdl_u.wr_addr.size());
        if (rec && mdl_u.wr_addr.size() == s + 2) begin
            chk("rec_addr", 64'h0FF0, mdl_u.wr_addr[s]);
            chk("rec_lin", xa, mdl_u.wr_data[s]);
            chk("rec_err_addr", 64'h0FF8, mdl_u.wr_addr[s+1]);
            if (chk_ec) begin
                chk("rec_err", {32'h0, xec}, mdl_u.wr_data[s+1]);
            end
        end
    endtask : fault

    task automatic t_size;
        rd("cap", `EFS_A_CAP, 32'h3);
        wr(`EFS_A_MASK, 32'h1);
        rd("size_b0", `EFS_A_MISC_SIZE, 32'h10);
        wr(`EFS_A_MASK, 32'h0);
        rd("size_none", `EFS_A_MISC_SIZE, 32'h0);
        wr(`EFS_A_CAP, 32'h0);
        wr(`EFS_A_MASK, 32'h1);
        rd("size_nocap", `EFS_A_MISC_SIZE, 32'h0);
        wr(`EFS_A_CAP, 32'h3);
    endtask : t_size

    task automatic t_faults;
        wr(`EFS_A_CTRL, 32'h1000);
        wr(`EFS_A_MASK, 32'h1);
        rd("rec_base", `EFS_A_REC_ADDR, 32'h0FF0);
        fault(`EFS_K_PF, PF_VA, 32'hFFFF_FFFF, 1'b1,
              PF_VA, 1'b1, 32'h0000_803F);
        fault(`EFS_K_GP, 64'h55AA, 32'h10, 1'b1, 64'h0, 1'b1,
              32'h10);
        fault(`EFS_K_PF, 64'h77, 32'h3, 1'b0, 64'h0, 1'b0, 32'h0);
        fault(`EFS_K_CP, 64'h99, 32'h0, 1'b0, 64'h0, 1'b0, 32'h0);
        wr(`EFS_A_MASK, 32'h2);
        fault(`EFS_K_CP, 64'h99, 32'h3F, 1'b1, 64'h0, 1'b1, 32'h0);
        fault(`EFS_K_GP, 64'h0, 32'h10, 1'b0, 64'h0, 1'b0, 32'h0);
    endtask : t_faults

    // Run once with both features present and once without them.
    task automatic t_tracker(input logic sup);
        int s;
        s = mdl_u.wr_addr.size();
        feat_sup <= sup;
        wr(`EFS_A_CF_ADDR, 32'h2000);
        wr(`EFS_A_FRAMES, 32'h0402);
        wr(`EFS_A_CF_SSP_LO, 32'h89AB_CDEF);
        wr(`EFS_A_CF_SSP_HI, 32'h0123_4567);
        wr(`EFS_A_CF_TRK, 32'hFFFF_FFFF);
        wait_idle();
        chk("cf_stores", s + 2, mdl_u.wr_addr.size());
        if (mdl_u.wr_addr.size() == s + 2) begin
            chk("ssp_addr", 64'h2020, mdl_u.wr_addr[s]);
            chk("ssp", sup ? 64'h0123_4567_89AB_CDEF : 64'h0,
                mdl_u.wr_data[s]);
            chk("trk_addr", 64'h2028, mdl_u.wr_addr[s+1]);
            chk("trk", sup ? 64'h3 : 64'h0, mdl_u.wr_data[s+1]);
        end
    endtask : t_tracker

    // Reserved flag bits must raise the status flag; defined ones must not.
    task automatic t_meta;
        logic [31:0] q;
        logic        e;
        wr(`EFS_A_META, 32'h0000_0F3F);
        wb(1'b0, `EFS_A_STATUS, 32'h0, q, e);
        chk("meta_ok", 1'b0, q[3]);
        wr(`EFS_A_META, 32'h0001_0000);
        wb(1'b0, `EFS_A_STATUS, 32'h0, q, e);
        chk("meta_hi", 1'b1, q[3]);
        wr(`EFS_A_META, 32'h0000_0040);
        wb(1'b0, `EFS_A_STATUS, 32'h0, q, e);
        chk("meta_gap", 1'b1, q[3]);
    endtask : t_meta

    // Software hands an aligned base and picks a field by index.
    task automatic t_desc;
        for (int i = 0; i < 4; i++) begin
            wr(`EFS_A_DESC, 32'h0000_3000 | (i << 2));
            rd("desc_field", `EFS_A_DESC_OUT, 32'h3000 + 8 * i);
        end
    endtask : t_desc

    task automatic t_unmapped;
        logic [31:0] q;
        logic        e;
        wb(1'b0, 8'h48, 32'h0, q, e);
        chk("err_rd", 1'b1, e);
        wb(1'b1, 8'hFC, 32'hFFFF_FFFF, q, e);
        chk("err_wr", 1'b1, e);
        rd("cap_kept", `EFS_A_CAP, 32'h3);
    endtask : t_unmapped

    // Inputs settle at time zero; reset spans four edges.
    initial begin
        reset  = 1'b1;
        wb_adr = 8'h0;
        wb_dat = 32'h0;
        wb_we  = 1'b0;
        wb_sel = 4'h0;
        wb_cyc = 1'b0;
        wb_stb = 1'b0;
        feat_sup = 1'b1;
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        t_size();
        t_faults();
        t_tracker(1'b1);
        t_tracker(1'b0);
        t_desc();
        t_meta();
        t_unmapped();
        wrap_up();
    end

    // A hang is cut well past the few hundred cycles the run needs.
    initial begin
        #100000;
        mismatches++;
        wrap_up();
    end
endmodule : efs_top_test
`default_nettype wire
